// File: logic/wdt_pkg.sv
// constants, field layouts and carrier types for the watchdog block
// assumes a single 25 MHz system clock and an asynchronous oscillator input
package wdt_pkg;

    localparam int unsigned SYS_CLK_HZ     = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned WDT_OSC_HZ     = 1_000_000;

    // register offsets
    localparam logic [7:0]  CTRL_ADDR      = 8'h00;
    localparam logic [7:0]  RSTAT_ADDR     = 8'h01;
    localparam logic [7:0]  ISTAT_ADDR     = 8'h02;
    localparam logic [7:0]  IMASK_ADDR     = 8'h03;

    // watchdog_control fields
    localparam int unsigned CE_BIT         = 4;
    localparam int unsigned WDE_BIT        = 3;
    localparam int unsigned SEL_LSB        = 0;
    localparam int unsigned SEL_W          = 3;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;

    // reset status and interrupt fields
    localparam int unsigned FLAG_BIT       = 3;
    localparam int unsigned IRQ_TIMEOUT    = 0;
    localparam int unsigned IRQ_EXPIRED    = 1;
    localparam int unsigned IRQ_W          = 2;
    localparam logic [1:0]  IMASK_RESET    = 2'h0;

    // change window: open for four system clock cycles
    localparam int unsigned CE_OPEN_CYCLES = 4;
    localparam logic [1:0]  CE_LOAD        = 2'(CE_OPEN_CYCLES - 1);

    // time-out counter
    localparam int unsigned CNT_W          = 22;
    localparam int unsigned BASE_TICKS_DEF = 16384;

    typedef enum logic {
        SEQ_CLOSED = 1'b0,
        SEQ_OPEN   = 1'b1
    } seq_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef struct packed {
        logic              osc_s1;
        logic              osc_s2;
        logic              osc_s3;
        logic              fuse_done;
        logic              level2;
        seq_t              seq;
        logic [1:0]        seq_cnt;
        logic              watchdog_enable;
        logic [SEL_W-1:0]  sel;
        logic [CNT_W-1:0]  cnt;
        logic              pulse;
        logic              rst_flag;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        logic [7:0]        rdata;
    } wdt_state_t;

    localparam wdt_state_t STATE_RESET = '0;

endpackage

// File: logic/wdt_timed_change.sv
// watchdog timer with timed two-write change sequence and safety levels
// assumes synchronous register strobes, a raw oscillator level and a fuse level
`timescale 1ns/1ns

module wdt_timed_change
    import wdt_pkg::*;
#(
    parameter int unsigned BASE_TICKS = BASE_TICKS_DEF
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire bus_req_t   i_bus,
    output logic [7:0]      o_rdata,
    input  wire logic       i_restart,
    input  wire logic       i_chip_reset,
    input  wire logic       i_wdt_osc,
    input  wire logic       i_always_on_fuse,
    output logic            o_chip_reset,
    output logic            o_irq
);

    function automatic logic [CNT_W-1:0] period_ticks(input logic [SEL_W-1:0] sel);
        logic [CNT_W-1:0] base;
        base = CNT_W'(BASE_TICKS);
        return base << sel;
    endfunction

    logic             rst_s1;
    logic             rst_n;
    wdt_state_t       st_reg;
    wdt_state_t       st_next;
    logic             tick;
    logic             ctrl_wr;
    logic             ctrl_open_wr;
    logic             chip_rst;
    logic             enabled;
    logic             timeout;
    logic             expired;
    logic [CNT_W-1:0] lim;

    // reset release through two flops
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    always_comb begin
        st_next        = st_reg;
        timeout        = 1'b0;
        expired        = 1'b0;
        ctrl_wr        = i_bus.wr && (i_bus.addr == CTRL_ADDR);
        // window opens only when change-enable and enable are written together
        ctrl_open_wr   = ctrl_wr && i_bus.wdata[CE_BIT] && i_bus.wdata[WDE_BIT];
        chip_rst       = st_reg.pulse | i_chip_reset;
        enabled        = st_reg.watchdog_enable | st_reg.level2;
        lim            = period_ticks(st_reg.sel);

        // oscillator edge through a two-flop synchroniser
        st_next.osc_s1 = i_wdt_osc;
        st_next.osc_s2 = st_reg.osc_s1;
        st_next.osc_s3 = st_reg.osc_s2;
        tick           = st_reg.osc_s2 & ~st_reg.osc_s3;

        // fuse caught once after reset release
        if (!st_reg.fuse_done) begin
            st_next.fuse_done = 1'b1;
            st_next.level2    = i_always_on_fuse;
        end

        // change window countdown
        if (st_reg.seq == SEQ_OPEN) begin
            if (st_reg.seq_cnt == 2'h0) begin
                st_next.seq = SEQ_CLOSED;
                expired     = 1'b1;
            end else begin
                st_next.seq_cnt = st_reg.seq_cnt - 2'h1;
            end
        end

        if (ctrl_wr) begin
            expired = 1'b0;
            if (ctrl_open_wr) begin
                st_next.seq     = SEQ_OPEN;
                st_next.seq_cnt = CE_LOAD;
            end else begin
                st_next.seq = SEQ_CLOSED;
            end
            if (i_bus.wdata[WDE_BIT]) begin
                st_next.watchdog_enable = 1'b1;
            end else if (st_reg.seq == SEQ_OPEN && !ctrl_open_wr && !st_reg.level2) begin
                st_next.watchdog_enable = 1'b0;
            end
            if (st_reg.seq == SEQ_OPEN && !ctrl_open_wr) begin
                st_next.sel = i_bus.wdata[SEL_LSB +: SEL_W];
            end
        end

        // time-out counter
        if (!enabled || i_restart || chip_rst) begin
            st_next.cnt = '0;
        end else if (tick) begin
            if (st_reg.cnt == lim - CNT_W'(1)) begin
                timeout     = 1'b1;
                st_next.cnt = '0;
            end else begin
                st_next.cnt = st_reg.cnt + CNT_W'(1);
            end
        end
        st_next.pulse = timeout;

        // chip reset returns control to its reset value
        if (chip_rst) begin
            st_next.seq     = SEQ_CLOSED;
            st_next.seq_cnt = 2'h0;
            st_next.watchdog_enable     = CTRL_RESET[WDE_BIT];
            st_next.sel     = CTRL_RESET[SEL_LSB +: SEL_W];
        end

        // reset flag: set wins over clear
        if (i_bus.wr && i_bus.addr == RSTAT_ADDR && !i_bus.wdata[FLAG_BIT]) begin
            st_next.rst_flag = 1'b0;
        end
        if (timeout) begin
            st_next.rst_flag = 1'b1;
        end

        // sticky interrupt status, write one to clear
        if (i_bus.wr && i_bus.addr == ISTAT_ADDR) begin
            st_next.irq_stat = st_reg.irq_stat & ~i_bus.wdata[IRQ_W-1:0];
        end
        st_next.irq_stat[IRQ_TIMEOUT] = st_next.irq_stat[IRQ_TIMEOUT] | timeout;
        st_next.irq_stat[IRQ_EXPIRED] = st_next.irq_stat[IRQ_EXPIRED] | expired;
        if (i_bus.wr && i_bus.addr == IMASK_ADDR) begin
            st_next.irq_mask = i_bus.wdata[IRQ_W-1:0];
        end

        // read data valid only in the cycle after the strobe
        st_next.rdata = 8'h00;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                CTRL_ADDR: begin
                    st_next.rdata = {3'h0, (st_reg.seq == SEQ_OPEN), enabled, st_reg.sel};
                end
                RSTAT_ADDR: begin
                    st_next.rdata = 8'(st_reg.rst_flag) << FLAG_BIT;
                end
                ISTAT_ADDR: begin
                    st_next.rdata = {6'h00, st_reg.irq_stat};
                end
                IMASK_ADDR: begin
                    st_next.rdata = {6'h00, st_reg.irq_mask};
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata      = st_reg.rdata;
    assign o_chip_reset = st_reg.pulse;
    assign o_irq        = |(st_reg.irq_stat & st_reg.irq_mask);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    sequence seq_open_write;
        ctrl_open_wr && !chip_rst;
    endsequence

    sequence seq_quiet_four;
        (!ctrl_wr && !chip_rst)[*4];
    endsequence

    sequence seq_quiet_three;
        (!ctrl_wr && !chip_rst)[*3];
    endsequence

    // second write of the timed pair, window still open
    sequence seq_second_write;
        ctrl_wr && !i_bus.wdata[CE_BIT] && st_reg.seq == SEQ_OPEN && !chip_rst;
    endsequence

    AST_CE_SELF_CLEAR: assert property (
        seq_open_write ##1 seq_quiet_four |=> (st_reg.seq == SEQ_CLOSED))
        else $error("change enable not cleared after four cycles");

    AST_CE_HELD_OPEN: assert property (
        seq_open_write |=> (st_reg.seq == SEQ_OPEN))
        else $error("change enable not set by write");

    AST_ENABLE_HELD: assert property (
        ctrl_wr && !i_bus.wdata[WDE_BIT] && st_reg.seq == SEQ_CLOSED && enabled && !chip_rst
        |=> enabled)
        else $error("watchdog disabled without change enable");

    AST_PRESCALE_LOCKED: assert property (
        st_reg.seq == SEQ_CLOSED && !chip_rst |=> st_reg.sel == $past(st_reg.sel))
        else $error("prescaler changed outside change window");

    AST_ENABLE_ANYTIME: assert property (
        ctrl_wr && i_bus.wdata[WDE_BIT] && !chip_rst |=> enabled)
        else $error("enable write did not enable watchdog");

    AST_LEVEL2_ON: assert property (
        st_reg.level2 && i_bus.rd && i_bus.addr == CTRL_ADDR |=> o_rdata[WDE_BIT])
        else $error("level 2 enable bit not read as one");

    AST_RESTART_CLEARS: assert property (
        i_restart |=> st_reg.cnt == '0)
        else $error("restart did not clear counter");

    AST_DISABLED_CLEARS: assert property (
        !enabled |=> st_reg.cnt == '0)
        else $error("counter not cleared while disabled");

    AST_TIMEOUT_RESET: assert property (
        enabled && tick && !i_restart && !chip_rst && st_reg.cnt == lim - CNT_W'(1)
        |=> o_chip_reset ##1 !o_chip_reset)
        else $error("time-out did not give a one-cycle reset pulse");

    AST_FLAG_ON_RESET: assert property (
        o_chip_reset && !i_chip_reset |-> st_reg.rst_flag)
        else $error("reset flag not set by time-out");

    AST_RESERVED_ZERO: assert property (
        i_bus.rd && i_bus.addr == CTRL_ADDR |=> o_rdata[7:5] == 3'h0)
        else $error("reserved control bits not zero");

    // window length, second write and clean-up after a time-out
    AST_WINDOW_FOUR: assert property (
        seq_open_write ##1 seq_quiet_three |=> (st_reg.seq == SEQ_OPEN))
        else $error("change enable cleared before four cycles");

    AST_OPEN_NEEDS_ENABLE: assert property (
        ctrl_wr && i_bus.wdata[CE_BIT] && !i_bus.wdata[WDE_BIT] && !chip_rst
        |=> st_reg.seq == SEQ_CLOSED)
        else $error("window opened without enable written");

    AST_PRESCALE_TAKEN: assert property (
        seq_second_write |=> st_reg.sel == $past(i_bus.wdata[SEL_LSB +: SEL_W]))
        else $error("prescaler not taken inside change window");

    AST_DISABLE_IN_WINDOW: assert property (
        seq_second_write ##0 (!i_bus.wdata[WDE_BIT] && !st_reg.level2) |=> !enabled)
        else $error("watchdog not disabled by timed sequence");

    AST_EXPIRE_IRQ: assert property (
        st_reg.seq == SEQ_OPEN && st_reg.seq_cnt == 2'h0 && !ctrl_wr
        |=> st_reg.irq_stat[IRQ_EXPIRED])
        else $error("window expiry not flagged");

    AST_CTRL_READ_OPEN: assert property (
        i_bus.rd && i_bus.addr == CTRL_ADDR && st_reg.seq == SEQ_OPEN |=> o_rdata[CE_BIT])
        else $error("change enable not read as one while open");

    AST_PULSE_CLEARS_CTRL: assert property (
        o_chip_reset |=> st_reg.seq == SEQ_CLOSED && !st_reg.watchdog_enable && st_reg.cnt == '0)
        else $error("time-out pulse did not clear control and counter");

    AST_FLAG_HELD: assert property (
        st_reg.rst_flag && !(i_bus.wr && i_bus.addr == RSTAT_ADDR && !i_bus.wdata[FLAG_BIT])
        |=> st_reg.rst_flag)
        else $error("reset flag lost without a written zero");

    AST_TIMEOUT_IRQ: assert property (
        o_chip_reset |-> st_reg.irq_stat[IRQ_TIMEOUT])
        else $error("time-out not flagged in interrupt status");

endmodule

// File: bench/wdt_timed_change_tb.sv
// self-checking bench for the watchdog with timed change sequence
// assumes the design carries its own assertions; short base period for speed
`timescale 1ns/1ns

module wdt_timed_change_tb;
    import wdt_pkg::*;

    localparam int unsigned TICKS = 4;

    logic       i_clk            = 1'b0;
    logic       i_reset_n        = 1'b0;
    logic       i_restart        = 1'b0;
    logic       i_chip_reset     = 1'b0;
    logic       i_wdt_osc        = 1'b0;
    logic       i_always_on_fuse = 1'b0;
    bus_req_t   i_bus            = '0;
    logic [7:0] o_rdata;
    logic       o_chip_reset;
    logic       o_irq;
    int         num_errors       = 0;
    int         tests_run        = 0;
    int         pulses           = 0;
    int         p;

    always #20 i_clk = ~i_clk;

    // counts cycles with the time-out reset high
    always @(posedge i_clk) if (o_chip_reset === 1'b1) pulses <= pulses + 1;

    wdt_timed_change #(.BASE_TICKS(TICKS)) wdt_timed_change_inst (
        .i_clk            (i_clk),
        .i_reset_n        (i_reset_n),
        .i_bus            (i_bus),
        .o_rdata          (o_rdata),
        .i_restart        (i_restart),
        .i_chip_reset     (i_chip_reset),
        .i_wdt_osc        (i_wdt_osc),
        .i_always_on_fuse (i_always_on_fuse),
        .o_chip_reset     (o_chip_reset),
        .o_irq            (o_irq)
    );

    task automatic test_done();
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus <= '0;
        @(posedge i_clk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus <= '0;
        #1;
        chk(o_rdata, exp);
        @(posedge i_clk);
    endtask

    // n oscillator periods, each long enough for the input synchroniser
    task automatic ticks(input int n);
        repeat (n) begin
            i_wdt_osc <= 1'b1;
            repeat (4) @(posedge i_clk);
            i_wdt_osc <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
    endtask

    // one-cycle pulse on the chip reset input or the restart input
    task automatic pulse(input logic chip);
        if (chip) begin
            i_chip_reset <= 1'b1;
        end else begin
            i_restart <= 1'b1;
        end
        @(posedge i_clk);
        i_restart    <= 1'b0;
        i_chip_reset <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic do_reset(input logic fuse);
        i_reset_n        <= 1'b0;
        i_always_on_fuse <= fuse;
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (6) @(posedge i_clk);
    endtask

    initial begin
        repeat (30000) @(posedge i_clk);
        num_errors++;
        test_done();
    end

    initial begin
        do_reset(1'b0);
        rdc(CTRL_ADDR, CTRL_RESET);
        rdc(8'h10, 8'h00);
        rdc(IMASK_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'he8);
        rdc(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h0f);
        rdc(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h00);
        rdc(CTRL_ADDR, 8'h08);
        // change-enable alone does not open the window
        wr(CTRL_ADDR, 8'h10);
        wr(CTRL_ADDR, 8'h00);
        rdc(CTRL_ADDR, 8'h08);
        // window left to run out
        wr(CTRL_ADDR, 8'h18);
        rdc(CTRL_ADDR, 8'h18);
        repeat (4) @(posedge i_clk);
        rdc(CTRL_ADDR, 8'h08);
        rdc(ISTAT_ADDR, 8'h02);
        wr(IMASK_ADDR, 8'h02);
        #1 chk({7'h0, o_irq}, 8'h01);
        wr(ISTAT_ADDR, 8'h02);
        #1 chk({7'h0, o_irq}, 8'h00);
        wr(IMASK_ADDR, 8'h00);
        // second write too late
        wr(CTRL_ADDR, 8'h18);
        repeat (6) @(posedge i_clk);
        wr(CTRL_ADDR, 8'h00);
        rdc(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h18);
        wr(CTRL_ADDR, 8'h00);
        rdc(CTRL_ADDR, 8'h00);
        // restart keeps the period from running out
        wr(CTRL_ADDR, 8'h18);
        wr(CTRL_ADDR, 8'h08);
        ticks(TICKS - 1);
        pulse(1'b0);
        ticks(TICKS - 1);
        chk(8'(pulses), 8'h00);
        ticks(1);
        chk(8'(pulses), 8'h01);
        rdc(CTRL_ADDR, 8'h00);
        rdc(RSTAT_ADDR, 8'h08);
        // expiry flag from the late second write is still pending
        rdc(ISTAT_ADDR, 8'h03);
        wr(IMASK_ADDR, 8'h01);
        #1 chk({7'h0, o_irq}, 8'h01);
        wr(ISTAT_ADDR, 8'h01);
        #1 chk({7'h0, o_irq}, 8'h00);
        wr(RSTAT_ADDR, 8'h08);
        rdc(RSTAT_ADDR, 8'h08);
        wr(RSTAT_ADDR, 8'h00);
        rdc(RSTAT_ADDR, 8'h00);
        ticks(2 * TICKS);
        chk(8'(pulses), 8'h01);
        wr(CTRL_ADDR, 8'h18);
        wr(CTRL_ADDR, 8'h08);
        ticks(TICKS - 1);
        pulse(1'b1);
        rdc(CTRL_ADDR, 8'h00);
        // every period code, one short of and at the limit
        for (int s = 0; s < 8; s++) begin
            wr(CTRL_ADDR, 8'h18);
            wr(CTRL_ADDR, 8'h08 | 8'(s));
            rdc(CTRL_ADDR, 8'h08 | 8'(s));
            p = pulses;
            ticks((TICKS << s) - 1);
            chk(8'(pulses), 8'(p));
            ticks(1);
            chk(8'(pulses), 8'(p + 1));
        end
        do_reset(1'b1);
        rdc(CTRL_ADDR, 8'h08);
        rdc(RSTAT_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h18);
        wr(CTRL_ADDR, 8'h00);
        rdc(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h18);
        wr(CTRL_ADDR, 8'h02);
        rdc(CTRL_ADDR, 8'h0a);
        wr(CTRL_ADDR, 8'h05);
        rdc(CTRL_ADDR, 8'h0a);
        test_done();
    end
endmodule
